// ===== aoi_pkg.sv
// Package for the converter output interface: widths, codes and timing constants.
// Assumes a single 40 MHz system clock and no register bus.
package aoi_pkg;
  // ----------------------------------------------------------------------
  // Widths and latency
  // ----------------------------------------------------------------------
  localparam int SAMPLE_W = 16;
  localparam int LATENCY = 7;
  localparam int MSB_POS = 15;
  localparam int LSB_POS = 0;
  // ----------------------------------------------------------------------
  // Format pin levels
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_OB_DCS_OFF = 2'h0;
  localparam logic [1:0] MODE_OB_DCS_ON = 2'h1;
  localparam logic [1:0] MODE_TC_DCS_ON = 2'h2;
  localparam logic [1:0] MODE_TC_DCS_OFF = 2'h3;
  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] SAMPLE_RST = 16'h0000;
  localparam logic DVN_RST = 1'b1;
endpackage

// ===== aoi_sync.sv
// Two flip-flop synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to i_clk.
`timescale 1ns/1ps
module aoi_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule // aoi_sync

// ===== aoi_top.sv
// Digital output side of a 16-bit pipelined sampling converter.
// Assumes encode and all strap pins are asynchronous and sampled by I_MCLK.
`timescale 1ns/1ps
// Operation
// RULE_01: Sample is taken at each rising edge of the positive encode input.
// RULE_02: Receiver may latch words on encode rising edge instead of strobes.
// RULE_03: Power-down high tri-states outputs; low is normal operation.
// RULE_04: Dither select high enables internal dither, low disables it.
// RULE_05: Result is a 16-bit parallel word, bit 15 most significant.
// RULE_06: Negative valid strobe toggles once per sample; latch on its fall.
// RULE_07: Positive valid strobe is the inverse; latch on its rise.
// RULE_08: Overflow flag is high when the sample exceeded range, else low.
// RULE_09: Output enable low drives outputs; high tri-states them.
// RULE_10: Four-level mode pin picks binary format and duty stabilizer.
// RULE_11: Scramble select high XORs bits 1 to 15 with bit 0.
// RULE_12: Receiver XORs received LSB into other bits to decode.
// RULE_13: Result of a sample appears seven encode cycles after its edge.
// RULE_14: Offset binary is two's complement with MSB inverted, before drivers.
module aoi_top #(
  parameter int SAMPLE_W = aoi_pkg::SAMPLE_W,
  parameter int LATENCY = aoi_pkg::LATENCY
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_ARST_N,
  // Encode and analog result
  input wire logic I_ENCODE_IN_POS,
  input wire logic [SAMPLE_W-1:0] I_ANALOG_CODE,
  input wire logic I_ANALOG_OVER,
  // Static controls
  input wire logic I_POWER_DOWN_PIN,
  input wire logic I_OUTPUT_EN_N,
  input wire logic I_DITHER_SELECT,
  input wire logic I_OUTPUT_SCRAMBLE_SELECT,
  input wire logic [1:0] I_MODE_LEVEL,
  // Sample outputs
  output logic [SAMPLE_W-1:0] O_SAMPLE_BITS,
  output logic [SAMPLE_W-1:0] O_SAMPLE_BITS_OE,
  output logic O_RANGE_OVERFLOW_FLAG,
  output logic O_RANGE_OVERFLOW_FLAG_OE,
  output logic O_VALID_STROBE_NEG,
  output logic O_VALID_STROBE_POS,
  output logic [1:0] O_VALID_STROBE_OE,
  // Status
  output logic O_DITHER_ACTIVE,
  output logic O_DUTY_CYCLE_STABILIZER,
  output logic O_ANALOG_POWERED
);
  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // The analog code is treated as a pin group; it must be stable around
  // the encode edge, since a wide bus through two flops is not coherent.
  localparam int SW = SAMPLE_W + 8;
  logic [SW-1:0] sync_q;
  aoi_sync #(.W(SW)) u_sync (
    .i_clk(I_MCLK),
    .i_arst_n(I_ARST_N),
    .i_d({I_ENCODE_IN_POS, I_ANALOG_OVER, I_POWER_DOWN_PIN, I_OUTPUT_EN_N,
          I_DITHER_SELECT, I_OUTPUT_SCRAMBLE_SELECT, I_MODE_LEVEL, I_ANALOG_CODE}),
    .o_q(sync_q)
  );
  logic enc_s, ovr_s, pd_s, oen_s, dither_select_s, scr_s;
  logic [1:0] mode_s;
  logic [SAMPLE_W-1:0] code_s;
  assign {enc_s, ovr_s, pd_s, oen_s, dither_select_s, scr_s, mode_s, code_s} = sync_q;

  function automatic logic [SAMPLE_W-1:0] fmt_word(input logic [SAMPLE_W-1:0] tc,
                                                   input logic [1:0] mode,
                                                   input logic scr);
    logic [SAMPLE_W-1:0] w;
    w = tc;
    // RULE_10 RULE_14 format select
    if (mode == aoi_pkg::MODE_OB_DCS_OFF || mode == aoi_pkg::MODE_OB_DCS_ON) begin
      w[SAMPLE_W-1] = ~tc[SAMPLE_W-1];
    end
    // RULE_11 output scramble
    if (scr) begin
      w[SAMPLE_W-1:1] = w[SAMPLE_W-1:1] ^ {(SAMPLE_W-1){w[0]}};
    end
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic enc_d;
    logic [LATENCY-1:0][SAMPLE_W-1:0] pipe;
    logic [LATENCY-1:0] pipe_ovr;
    logic [SAMPLE_W-1:0] data;
    logic ovr;
    logic dvn;
    logic dvp;
    logic oe;
    logic dither_select;
    logic duty_cycle_stabilizer;
    logic pwr;
  } aoi_state_t;
  aoi_state_t st, next_st;

  logic enc_rise;
  assign enc_rise = enc_s & ~st.enc_d;

  always_comb begin
    next_st = st;
    next_st.enc_d = enc_s;
    // RULE_04 dither enable
    next_st.dither_select = dither_select_s & ~pd_s;
    next_st.duty_cycle_stabilizer = (mode_s == aoi_pkg::MODE_OB_DCS_ON) || (mode_s == aoi_pkg::MODE_TC_DCS_ON);
    // RULE_03 RULE_09 output enable
    next_st.oe = ~pd_s & ~oen_s;
    next_st.pwr = ~pd_s;
    // RULE_01 RULE_13 sample and pipeline
    if (enc_rise && !pd_s) begin
      next_st.pipe[0] = code_s;
      next_st.pipe_ovr[0] = ovr_s;
      for (int i = 1; i < LATENCY; i++) begin
        next_st.pipe[i] = st.pipe[i-1];
        next_st.pipe_ovr[i] = st.pipe_ovr[i-1];
      end
      // RULE_05 RULE_08 word and flag
      next_st.data = fmt_word(st.pipe[LATENCY-1], mode_s, scr_s);
      next_st.ovr = st.pipe_ovr[LATENCY-1];
      // RULE_06 RULE_07 valid strobes
      next_st.dvn = ~st.dvn;
      next_st.dvp = st.dvn;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st <= '0;
      st.dvn <= aoi_pkg::DVN_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign O_SAMPLE_BITS = st.data;
  assign O_SAMPLE_BITS_OE = {SAMPLE_W{st.oe}};
  assign O_RANGE_OVERFLOW_FLAG = st.ovr;
  assign O_RANGE_OVERFLOW_FLAG_OE = st.oe;
  assign O_VALID_STROBE_NEG = st.dvn;
  assign O_VALID_STROBE_POS = st.dvp;
  assign O_VALID_STROBE_OE = {2{st.oe}};
  assign O_DITHER_ACTIVE = st.dither_select;
  assign O_DUTY_CYCLE_STABILIZER = st.duty_cycle_stabilizer;
  assign O_ANALOG_POWERED = st.pwr;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_ARST_N);

  strobe_inverse_a: assert property (O_VALID_STROBE_POS == ~O_VALID_STROBE_NEG) // RULE_07
    else $error("positive strobe not inverse of negative");
  strobe_toggle_a: assert property (enc_rise && !pd_s |=> O_VALID_STROBE_NEG != $past(O_VALID_STROBE_NEG)) // RULE_06
    else $error("negative strobe did not toggle on sample");
  strobe_hold_a: assert property (!enc_rise |=> $stable(O_VALID_STROBE_NEG)) // RULE_06
    else $error("negative strobe moved without sample");
  tristate_ctl_a: assert property ((pd_s || oen_s) |=> !O_SAMPLE_BITS_OE[0] && !O_VALID_STROBE_OE[0]) // RULE_03
    else $error("outputs driven while disabled");
  drive_ctl_a: assert property ((!pd_s && !oen_s) |=> O_SAMPLE_BITS_OE[0]) // RULE_09
    else $error("outputs not driven while enabled");
  dither_ctl_a: assert property (##1 O_DITHER_ACTIVE == $past(dither_select_s && !pd_s)) // RULE_04
    else $error("dither state wrong");
  dcs_ctl_a: assert property (##1 O_DUTY_CYCLE_STABILIZER == $past(mode_s == 2'h1 || mode_s == 2'h2)) // RULE_10
    else $error("stabilizer state wrong");
  latency_word_a: assert property (enc_rise && !pd_s && !scr_s && mode_s == 2'h3
      |=> O_SAMPLE_BITS == $past(st.pipe[LATENCY-1])) // RULE_13
    else $error("output word not seven samples late");
  overflow_path_a: assert property (enc_rise && !pd_s |=> O_RANGE_OVERFLOW_FLAG == $past(st.pipe_ovr[LATENCY-1])) // RULE_08
    else $error("overflow flag not aligned");
  sample_take_a: assert property (enc_rise && !pd_s |=> st.pipe[0] == $past(code_s)) // RULE_01
    else $error("sample not held on encode edge");

  cover_sample_c: cover property (enc_rise && !pd_s);
  cover_scramble_c: cover property (enc_rise && scr_s && !pd_s);
  cover_shutdown_c: cover property (pd_s ##1 !pd_s);
  cover_overflow_c: cover property (O_RANGE_OVERFLOW_FLAG);
endmodule // aoi_top

// ===== aoi_rx.sv
// Receiving logic model: latches output words and decodes them.
// Assumes registered device outputs that settle well before the next encode rise.
`timescale 1ns/1ps
module aoi_rx (
  // Link
  input wire logic i_enc,
  input wire logic [15:0] i_bits,
  input wire logic i_of,
  input wire logic i_neg,
  // Decode setup
  input wire logic i_scr,
  input wire logic i_ob,
  // Decoded capture
  output logic [15:0] o_word,
  output logic o_of,
  output logic o_neg
);
  logic [15:0] dec;
  // offset binary back to two's complement.
  always_comb begin
    dec = i_bits;
    if (i_scr) dec[15:1] = i_bits[15:1] ^ {15{i_bits[0]}};
    if (i_ob) dec[15] = ~dec[15];
  end
  // latch on encode
  // Latching on encode avoids missing every other word of a toggling strobe.
  always @(posedge i_enc) begin
    o_word <= dec;
    o_of <= i_of;
    o_neg <= i_neg;
  end
endmodule // aoi_rx

// ===== tb_adc_output_interface.sv
// Testbench for the converter output interface.
// Assumes encode period of 8 clocks and the receiver model aoi_rx.
`timescale 1ns/1ps
module tb_adc_output_interface;
  localparam int LAG = aoi_pkg::LATENCY + 1;
  logic clk = 1'b0, arst_n = 1'b0, enc = 1'b0, over = 1'b0, pd = 1'b0, oe_n = 1'b0;
  logic dither_select = 1'b0, scr = 1'b0, last = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [15:0] code = 16'h0000;
  logic [15:0] bits, bits_oe, rx_word;
  logic of, of_oe, neg, pos, d_act, duty_cycle_stabilizer, pwr, rx_of, rx_neg;
  logic [1:0] s_oe;
  logic [15:0] hist [0:511];
  logic hov [0:511];
  int n = 0, err_total = 0, check_count = 0, cyc = 0;
  initial forever #12.5 clk = ~clk;
  aoi_top dut_u (.I_MCLK(clk), .I_ARST_N(arst_n), .I_ENCODE_IN_POS(enc),
    .I_ANALOG_CODE(code), .I_ANALOG_OVER(over), .I_POWER_DOWN_PIN(pd),
    .I_OUTPUT_EN_N(oe_n), .I_DITHER_SELECT(dither_select), .I_OUTPUT_SCRAMBLE_SELECT(scr),
    .I_MODE_LEVEL(mode), .O_SAMPLE_BITS(bits), .O_SAMPLE_BITS_OE(bits_oe),
    .O_RANGE_OVERFLOW_FLAG(of), .O_RANGE_OVERFLOW_FLAG_OE(of_oe),
    .O_VALID_STROBE_NEG(neg), .O_VALID_STROBE_POS(pos), .O_VALID_STROBE_OE(s_oe),
    .O_DITHER_ACTIVE(d_act), .O_DUTY_CYCLE_STABILIZER(duty_cycle_stabilizer), .O_ANALOG_POWERED(pwr));
  aoi_rx rx_u (.i_enc(enc), .i_bits(bits), .i_of(of), .i_neg(neg), .i_scr(scr),
    .i_ob(~mode[1]), .o_word(rx_word), .o_of(rx_of), .o_neg(rx_neg));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task test_done;
    $display("mismatches %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      test_done();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  // Code is set in the low half so it is stable around the rise.
  task automatic enc_cycle(input logic [15:0] c, input logic ov);
    code = c;
    over = ov;
    tick(4);
    enc = 1'b1;
    tick(4);
    enc = 1'b0;
  endtask
  task automatic run_cfg(input logic [1:0] m, input logic s);
    mode = m;
    scr = s;
    dither_select = s;
    for (int i = 0; i < 16; i++) begin
      hist[n] = {n[7:0] ^ 8'ha5, ~n[7:0]};
      hov[n] = n[0] & n[1];
      enc_cycle(hist[n], hov[n]);
      if (i >= 10) begin
        chk("word", hist[n - LAG], rx_word);
        chk("overflow", {15'h0, hov[n - LAG]}, {15'h0, rx_of});
        chk("strobe toggle", {15'h0, ~last}, {15'h0, rx_neg});
      end
      last = rx_neg;
      n++;
    end
    chk("stabilizer", {15'h0, m == 2'h1 || m == 2'h2}, {15'h0, duty_cycle_stabilizer});
    chk("dither", {15'h0, s}, {15'h0, d_act});
    chk("strobe pair", {15'h0, ~neg}, {15'h0, pos});
  endtask
  task automatic off_test;
    oe_n = 1'b1;
    tick(6);
    chk("data oe off", 16'h0000, bits_oe);
    chk("misc oe off", 16'h0000, {13'h0, of_oe, s_oe});
    oe_n = 1'b0;
    tick(6);
    chk("data oe on", 16'hffff, bits_oe);
    chk("misc oe on", 16'h0007, {13'h0, of_oe, s_oe});
    pd = 1'b1;
    tick(6);
    chk("pd oe", 16'h0000, bits_oe);
    chk("pd power", 16'h0000, {15'h0, pwr});
    last = neg;
    repeat (3) enc_cycle(16'h1234, 1'b1);
    chk("pd frozen", {15'h0, last}, {15'h0, neg});
    pd = 1'b0;
    tick(6);
    chk("wake power", 16'h0001, {15'h0, pwr});
    chk("wake oe", 16'hffff, bits_oe);
    last = rx_neg;
  endtask
  initial begin
    tick(20);
    chk("reset strobe", 16'h0001, {15'h0, neg});
    arst_n = 1'b1;
    tick(4);
    for (int m = 0; m < 4; m++) begin
      run_cfg(m[1:0], 1'b0);
      run_cfg(m[1:0], 1'b1);
    end
    off_test();
    run_cfg(2'h3, 1'b1);
    test_done();
  end
endmodule // tb_adc_output_interface
